// ### logic/lmq_event_unit.sv
// Sticky event flags with acknowledge and one interrupt line.
// Assumes events are one-cycle pulses from device logic.
`timescale 1ns/1ps
module lmq_event_unit
  import lmq_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire logic [LMQ_EVENT_BITS-1:0] event_set,
  input  wire logic                      ack_we,
  input  wire logic [LMQ_EVENT_BITS-1:0] ack_mask,
  input  wire logic                      clear_all,
  output logic      [LMQ_EVENT_BITS-1:0] flags,
  output logic                           irq
);
  always_ff @(posedge clk)
  begin
    if (srst)
      flags <= '0;
    else if (ce)
    begin
      if (clear_all)
        flags <= event_set;
      else
        flags <= (flags & ~(ack_we ? ack_mask : '0)) | event_set;
    end
  end

  assign irq = |flags;

  AST_EVENT_STICKS: assert property (@(posedge clk) disable iff (srst)
    ce && event_set[0] |=> flags[0])
    else $error("event flag not set");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (srst)
    ce && event_set != '0 |=> irq)
    else $error("interrupt line mismatch");
  AST_IRQ_HOLDS: assert property (@(posedge clk) disable iff (srst)
    ce && irq && !ack_we && !clear_all |=> irq)
    else $error("interrupt dropped without ack");
  AST_FLAG_HOLDS: assert property (@(posedge clk) disable iff (srst)
    flags[1] && ce && !ack_we && !clear_all |=> flags[1])
    else $error("flag dropped without ack");
endmodule

// ### logic/lmq_pkg.sv
// Package for the legacy page-based queue register bank.
// Assumes a single 20 MHz clock and synchronous active-high reset.
package lmq_pkg;
  // Register byte offsets
  localparam logic [11:0] LMQ_OFS_SIGNATURE   = 12'h000;
  localparam logic [11:0] LMQ_OFS_VERSION     = 12'h004;
  localparam logic [11:0] LMQ_OFS_DEV_IDENT   = 12'h008;
  localparam logic [11:0] LMQ_OFS_VEN_IDENT   = 12'h00c;
  localparam logic [11:0] LMQ_OFS_OFFER_FEAT  = 12'h010;
  localparam logic [11:0] LMQ_OFS_OFFER_SEL   = 12'h014;
  localparam logic [11:0] LMQ_OFS_ACCEPT_FEAT = 12'h020;
  localparam logic [11:0] LMQ_OFS_ACCEPT_SEL  = 12'h024;
  localparam logic [11:0] LMQ_OFS_PAGE_BYTES  = 12'h028;
  localparam logic [11:0] LMQ_OFS_RING_SEL    = 12'h030;
  localparam logic [11:0] LMQ_OFS_RING_MAX    = 12'h034;
  localparam logic [11:0] LMQ_OFS_RING_COUNT  = 12'h038;
  localparam logic [11:0] LMQ_OFS_USED_ALIGN  = 12'h03c;
  localparam logic [11:0] LMQ_OFS_PAGE_FRAME  = 12'h040;
  localparam logic [11:0] LMQ_OFS_DOORBELL    = 12'h050;
  localparam logic [11:0] LMQ_OFS_EVENT_FLAGS = 12'h060;
  localparam logic [11:0] LMQ_OFS_EVENT_CLEAR = 12'h064;
  localparam logic [11:0] LMQ_OFS_STATUS      = 12'h070;
  // Fixed read values
  localparam logic [31:0] LMQ_LAYOUT_VERSION  = 32'h0000_0001;
  localparam logic [31:0] LMQ_ZERO_WORD       = 32'h0000_0000;
  // Sizes of the bank
  localparam int          LMQ_NUM_RINGS       = 4;
  localparam int          LMQ_RING_W          = 2;
  localparam int          LMQ_FEAT_WORDS      = 2;
  localparam int          LMQ_EVENT_BITS      = 2;
  // Values after reset
  localparam logic [31:0] LMQ_RST_PAGE_BYTES  = 32'h0000_1000;
  localparam logic [31:0] LMQ_RST_ALIGN       = 32'h0000_1000;
endpackage

// ### logic/lmq_regs.sv
// Legacy page-based queue register bank of a paravirtual device.
// Assumes 32-bit aligned word accesses synchronous to clk; one-cycle
// read latency; reads of write-only or unmapped offsets return zero.
`timescale 1ns/1ps
module lmq_regs
  import lmq_pkg::*;
#(
  parameter logic [31:0] SIGNATURE  = 32'h0000_0000, // Arbitrary value
  parameter logic [31:0] DEV_IDENT  = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] VEN_IDENT  = 32'h0000_0002, // Arbitrary value
  parameter logic [31:0] RING_MAX   = 32'h0000_0100,
  parameter logic [31:0] OFFER_W0   = 32'h0000_0001,
  parameter logic [31:0] OFFER_W1   = 32'h0000_0000
)
(
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [11:0]               reg_addr,
  input  wire logic [31:0]               reg_wdata,
  output logic      [31:0]               reg_rdata,
  output logic                           reg_rvalid,
  input  wire logic [LMQ_EVENT_BITS-1:0] event_set,
  output logic                           irq,
  output logic      [31:0]               accepted_w0,
  output logic      [31:0]               accepted_w1,
  output logic      [31:0]               dev_status,
  output logic                           doorbell_pulse,
  output logic      [15:0]               doorbell_ring,
  output logic      [63:0]               ring_base,
  output logic      [63:0]               used_base,
  output logic                           ring_active
);
  logic [31:0]               offer_sel;
  logic [31:0]               accept_sel;
  logic [31:0]               page_bytes;
  logic [31:0]               ring_sel;
  logic [LMQ_EVENT_BITS-1:0] flags;
  logic                      wr_zero_status;
  logic                      sel_valid;
  logic [63:0]               desc_end;
  logic [63:0]               base_prod;
  logic [63:0]               align_m1;
  logic [31:0]               rd_word;
  lmq_ring_if                rif ();

  assign wr_zero_status = reg_wr && reg_addr == LMQ_OFS_STATUS
                          && reg_wdata == LMQ_ZERO_WORD;
  assign sel_valid = ring_sel < 32'(LMQ_NUM_RINGS);

  // Selectors and page size
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      offer_sel  <= LMQ_ZERO_WORD;
      accept_sel <= LMQ_ZERO_WORD;
      page_bytes <= LMQ_RST_PAGE_BYTES;
      ring_sel   <= LMQ_ZERO_WORD;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == LMQ_OFS_OFFER_SEL)
        offer_sel <= reg_wdata;
      if (reg_addr == LMQ_OFS_ACCEPT_SEL)
        accept_sel <= reg_wdata;
      if (reg_addr == LMQ_OFS_PAGE_BYTES)
        page_bytes <= reg_wdata;
      if (reg_addr == LMQ_OFS_RING_SEL)
        ring_sel <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || (ce && wr_zero_status))
    begin
      accepted_w0 <= LMQ_ZERO_WORD;
      accepted_w1 <= LMQ_ZERO_WORD;
    end
    else if (ce && reg_wr && reg_addr == LMQ_OFS_ACCEPT_FEAT)
    begin
      if (accept_sel == 32'h0000_0000)
        accepted_w0 <= reg_wdata;
      else if (accept_sel == 32'h0000_0001)
        accepted_w1 <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      dev_status <= LMQ_ZERO_WORD;
    else if (ce && reg_wr && reg_addr == LMQ_OFS_STATUS)
    begin
      if (reg_wdata == LMQ_ZERO_WORD)
        dev_status <= LMQ_ZERO_WORD;
      else
        dev_status <= dev_status | reg_wdata;
    end
  end

  // Doorbell pulse with low 16 bits
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      doorbell_pulse <= 1'b0;
      doorbell_ring  <= 16'h0000;
    end
    else if (ce)
    begin
      doorbell_pulse <= reg_wr && reg_addr == LMQ_OFS_DOORBELL;
      if (reg_wr && reg_addr == LMQ_OFS_DOORBELL)
        doorbell_ring <= reg_wdata[15:0];
    end
  end

  // Ring store writes, only for existing rings
  assign rif.sel       = ring_sel[LMQ_RING_W-1:0];
  assign rif.wdata     = reg_wdata;
  assign rif.clear_all = ce && wr_zero_status;
  assign rif.wr_count  = reg_wr && sel_valid && reg_addr == LMQ_OFS_RING_COUNT;
  assign rif.wr_align  = reg_wr && sel_valid && reg_addr == LMQ_OFS_USED_ALIGN;
  assign rif.wr_frame  = reg_wr && sel_valid && reg_addr == LMQ_OFS_PAGE_FRAME;

  lmq_ring_store u_store (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .rif  (rif.store)
  );

  lmq_event_unit u_event (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .event_set (event_set),
    .ack_we    (reg_wr && reg_addr == LMQ_OFS_EVENT_CLEAR),
    .ack_mask  (reg_wdata[LMQ_EVENT_BITS-1:0]),
    .clear_all (wr_zero_status),
    .flags     (flags),
    .irq       (irq)
  );

  // Read mux
  always_comb
  begin
    rd_word = LMQ_ZERO_WORD;
    unique case (reg_addr)
      LMQ_OFS_SIGNATURE:   rd_word = SIGNATURE;
      LMQ_OFS_VERSION:     rd_word = LMQ_LAYOUT_VERSION;
      LMQ_OFS_DEV_IDENT:   rd_word = DEV_IDENT;
      LMQ_OFS_VEN_IDENT:   rd_word = VEN_IDENT;
      LMQ_OFS_OFFER_FEAT:
        rd_word = offer_sel == 32'h0000_0000 ? OFFER_W0 :
                  offer_sel == 32'h0000_0001 ? OFFER_W1 : LMQ_ZERO_WORD;
      LMQ_OFS_RING_MAX:    rd_word = sel_valid ? RING_MAX : LMQ_ZERO_WORD;
      LMQ_OFS_PAGE_FRAME:  rd_word = sel_valid ? rif.frame : LMQ_ZERO_WORD;
      LMQ_OFS_EVENT_FLAGS: rd_word = 32'(flags);
      LMQ_OFS_STATUS:      rd_word = dev_status;
      default:             rd_word = LMQ_ZERO_WORD;
    endcase
  end

  // Registered read data
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata  <= LMQ_ZERO_WORD;
      reg_rvalid <= 1'b0;
    end
    else if (ce)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_word;
    end
  end

  assign base_prod = 64'(rif.frame) * 64'(page_bytes);
  assign desc_end = base_prod
                    + 64'(rif.count) * 64'h0000_0000_0000_0010
                    + 64'h0000_0000_0000_0006
                    + 64'(rif.count) * 64'h0000_0000_0000_0002;
  assign align_m1 = 64'(rif.align) - 64'h0000_0000_0000_0001;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ring_base   <= 64'h0000_0000_0000_0000;
      used_base   <= 64'h0000_0000_0000_0000;
      ring_active <= 1'b0;
    end
    else if (ce)
    begin
      ring_base   <= base_prod;
      used_base   <= (desc_end + align_m1) & ~align_m1;
      ring_active <= sel_valid && rif.frame != LMQ_ZERO_WORD;
    end
  end

  // Checks on register behaviour
  // version reads one
  AST_VERSION_ONE: assert property (@(posedge clk) disable iff (srst)
    ce && reg_rd && reg_addr == LMQ_OFS_VERSION
    |=> reg_rvalid && reg_rdata == 32'h0000_0001)
    else $error("version not one");

  AST_MAX_ABSENT: assert property (@(posedge clk) disable iff (srst)
    ce && reg_rd && reg_addr == LMQ_OFS_RING_MAX && !sel_valid
    |=> reg_rdata == 32'h0000_0000)
    else $error("absent ring max not zero");

  AST_MAX_PRESENT: assert property (@(posedge clk) disable iff (srst)
    ce && reg_rd && reg_addr == LMQ_OFS_RING_MAX && sel_valid
    |=> reg_rdata == RING_MAX)
    else $error("present ring max wrong");

  AST_FRAME_READBACK: assert property (@(posedge clk) disable iff (srst)
    ce && reg_wr && reg_addr == LMQ_OFS_PAGE_FRAME && sel_valid
    ##1 ce && !reg_wr
    ##1 ce && reg_rd && reg_addr == LMQ_OFS_PAGE_FRAME && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("frame readback mismatch");

  AST_FRAME_ABSENT: assert property (@(posedge clk) disable iff (srst)
    ce && reg_rd && reg_addr == LMQ_OFS_PAGE_FRAME && !sel_valid
    |=> reg_rdata == 32'h0000_0000)
    else $error("absent ring frame not zero");

  AST_STATUS_CLEARS: assert property (@(posedge clk) disable iff (srst)
    ce && wr_zero_status ##1 ce && !reg_wr |=> rif.frame == 32'h0000_0000)
    else $error("frame not cleared by status zero");

  AST_STATUS_SETS: assert property (@(posedge clk) disable iff (srst)
    ce && reg_wr && reg_addr == LMQ_OFS_STATUS && reg_wdata != 32'h0000_0000
    |=> dev_status == ($past(dev_status) | $past(reg_wdata)))
    else $error("status flags not set");

  AST_STATUS_ZERO: assert property (@(posedge clk) disable iff (srst)
    ce && wr_zero_status |=> dev_status == 32'h0000_0000
    && accepted_w0 == 32'h0000_0000 && accepted_w1 == 32'h0000_0000)
    else $error("status zero did not reset");

  AST_ACCEPT_W1: assert property (@(posedge clk) disable iff (srst)
    ce && reg_wr && reg_addr == LMQ_OFS_ACCEPT_FEAT
    && accept_sel == 32'h0000_0001 |=> accepted_w1 == $past(reg_wdata))
    else $error("accepted word not captured");

  AST_ACCEPT_W0: assert property (@(posedge clk) disable iff (srst)
    ce && reg_wr && reg_addr == LMQ_OFS_ACCEPT_FEAT
    && accept_sel == 32'h0000_0000 |=> accepted_w0 == $past(reg_wdata))
    else $error("accepted word zero not captured");

  AST_ACTIVE_ZERO: assert property (@(posedge clk) disable iff (srst)
    ce && rif.frame == 32'h0000_0000 |=> !ring_active)
    else $error("zero frame seen as active");

  AST_ACTIVE_SET: assert property (@(posedge clk) disable iff (srst)
    ce && sel_valid && rif.frame != 32'h0000_0000 |=> ring_active)
    else $error("configured ring not active");

  AST_BASE_PRODUCT: assert property (@(posedge clk) disable iff (srst)
    ce |=> ring_base == $past(base_prod))
    else $error("ring base wrong");

  AST_OFFER_SEL: assert property (@(posedge clk) disable iff (srst)
    ce && reg_rd && reg_addr == LMQ_OFS_OFFER_FEAT
    && offer_sel == 32'h0000_0001 |=> reg_rdata == OFFER_W1)
    else $error("offered word wrong");

  AST_OFFER_W0: assert property (@(posedge clk) disable iff (srst)
    ce && reg_rd && reg_addr == LMQ_OFS_OFFER_FEAT
    && offer_sel == 32'h0000_0000 |=> reg_rdata == OFFER_W0)
    else $error("offered word zero wrong");

  AST_DEV_IDENT: assert property (@(posedge clk) disable iff (srst)
    ce && reg_rd && reg_addr == LMQ_OFS_DEV_IDENT |=> reg_rdata == DEV_IDENT)
    else $error("device identifier wrong");

  AST_SEL_TAKEN: assert property (@(posedge clk) disable iff (srst)
    ce && reg_wr && reg_addr == LMQ_OFS_RING_SEL
    |=> ring_sel == $past(reg_wdata))
    else $error("selector not taken");

  AST_SEL_FROZEN: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(ring_sel))
    else $error("selector moved while disabled");
endmodule

// ### logic/lmq_ring_if.sv
// Interface carrying per-ring store accesses between bank and ring store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface lmq_ring_if;
  import lmq_pkg::*;
  logic [LMQ_RING_W-1:0] sel;
  logic                  wr_count;
  logic                  wr_align;
  logic                  wr_frame;
  logic                  clear_all;
  logic [31:0]           wdata;
  logic [31:0]           count;
  logic [31:0]           align;
  logic [31:0]           frame;
  modport bank  (output sel, wr_count, wr_align, wr_frame, clear_all,
                 wdata, input count, align, frame);
  modport store (input sel, wr_count, wr_align, wr_frame, clear_all,
                 wdata, output count, align, frame);
endinterface

// ### logic/lmq_ring_store.sv
// Small per-ring memory: element count, used-ring alignment, page frame.
// Assumes writes come from the register bank; read data are registered.
`timescale 1ns/1ps
module lmq_ring_store
  import lmq_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  lmq_ring_if.store rif
);
  logic [31:0] count_mem [LMQ_NUM_RINGS];
  logic [31:0] align_mem [LMQ_NUM_RINGS];
  logic [31:0] frame_mem [LMQ_NUM_RINGS];

  // One entry per ring
  for (genvar g = 0; g < LMQ_NUM_RINGS; g++)
  begin : g_ring
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        count_mem[g] <= LMQ_ZERO_WORD;
        align_mem[g] <= LMQ_RST_ALIGN;
        frame_mem[g] <= LMQ_ZERO_WORD;
      end
      else if (ce)
      begin
        if (rif.wr_count && rif.sel == LMQ_RING_W'(g))
          count_mem[g] <= rif.wdata;
        if (rif.wr_align && rif.sel == LMQ_RING_W'(g))
          align_mem[g] <= rif.wdata;
        if (rif.clear_all)
          frame_mem[g] <= LMQ_ZERO_WORD;
        else if (rif.wr_frame && rif.sel == LMQ_RING_W'(g))
          frame_mem[g] <= rif.wdata;
      end
    end
  end

  // Registered read of selected entry
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rif.count <= LMQ_ZERO_WORD;
      rif.align <= LMQ_RST_ALIGN;
      rif.frame <= LMQ_ZERO_WORD;
    end
    else if (ce)
    begin
      rif.count <= count_mem[rif.sel];
      rif.align <= align_mem[rif.sel];
      rif.frame <= frame_mem[rif.sel];
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the legacy page-based queue register bank.
// Assumes lmq_regs alone on one 20 MHz clock with sync active-high reset.
`timescale 1ns/1ps
module tb_top;
  import lmq_pkg::*;
  localparam logic [31:0] SIG_V = 32'h1234_5678; // Arbitrary value
  localparam logic [31:0] DEV_V = 32'h0000_0abc; // Arbitrary value
  localparam logic [31:0] VEN_V = 32'h0000_0def; // Arbitrary value
  localparam logic [31:0] MAX_V = 32'h0000_0100;
  localparam logic [31:0] OF0_V = 32'h8000_0011;
  localparam logic [31:0] OF1_V = 32'h0000_0005;
  logic                      clk;
  logic                      srst;
  logic                      ce;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [11:0]               reg_addr;
  logic [31:0]               reg_wdata;
  logic [31:0]               reg_rdata;
  logic                      reg_rvalid;
  logic [LMQ_EVENT_BITS-1:0] event_set;
  logic                      irq;
  logic [31:0]               accepted_w0;
  logic [31:0]               accepted_w1;
  logic [31:0]               dev_status;
  logic                      doorbell_pulse;
  logic [15:0]               doorbell_ring;
  logic [63:0]               ring_base;
  logic [63:0]               used_base;
  logic                      ring_active;
  logic [31:0]               page;
  logic [31:0]               cnt;
  logic [31:0]               algn;
  logic [31:0]               val;
  logic [31:0]               fr [LMQ_NUM_RINGS];
  int                        errors;
  int                        checks_done;
  int                        seed;

  // Design under test
  lmq_regs #(
    .SIGNATURE (SIG_V),
    .DEV_IDENT (DEV_V),
    .VEN_IDENT (VEN_V),
    .RING_MAX  (MAX_V),
    .OFFER_W0  (OF0_V),
    .OFFER_W1  (OF1_V)
  ) dut (
    .clk            (clk),
    .srst           (srst),
    .ce             (ce),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata),
    .reg_rvalid     (reg_rvalid),
    .event_set      (event_set),
    .irq            (irq),
    .accepted_w0    (accepted_w0),
    .accepted_w1    (accepted_w1),
    .dev_status     (dev_status),
    .doorbell_pulse (doorbell_pulse),
    .doorbell_ring  (doorbell_ring),
    .ring_base      (ring_base),
    .used_base      (used_base),
    .ring_active    (ring_active)
  );

  // Clock, 50 ns period
  always #25 clk = ~clk;

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Summary and end of run
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One-cycle write strobe, written registers settled on return; ring_base, used_base and ring_active need two more edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe, data checked with its valid pulse
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({63'h0, reg_rvalid}, 64'h1);
    check({32'h0, reg_rdata}, {32'h0, exp});
  endtask

  // Used ring start: descriptor table and available ring rounded up to the alignment
  function automatic logic [63:0] used_exp(input logic [63:0] base,
    input logic [31:0] n, input logic [31:0] al);
    logic [63:0] off;
    off = 64'(n) * 64'h12 + 64'h6;
    return base + ((off + 64'(al) - 64'h1) / 64'(al)) * 64'(al);
  endfunction

  // Watchdog against a hang
  initial
  begin
    #1_000_000;
    errors++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    event_set = '0;
    errors = 0;
    checks_done = 0;
    seed = 20220;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd_chk(LMQ_OFS_VERSION, LMQ_LAYOUT_VERSION);
    rd_chk(LMQ_OFS_DEV_IDENT, DEV_V);
    rd_chk(LMQ_OFS_VEN_IDENT, VEN_V);
    rd_chk(LMQ_OFS_SIGNATURE, SIG_V);
    rd_chk(12'h0fc, LMQ_ZERO_WORD);
    rd_chk(LMQ_OFS_PAGE_BYTES, LMQ_ZERO_WORD);
    wr(LMQ_OFS_OFFER_SEL, 32'h0000_0001);
    rd_chk(LMQ_OFS_OFFER_FEAT, OF1_V);
    wr(LMQ_OFS_OFFER_SEL, 32'h0000_0000);
    rd_chk(LMQ_OFS_OFFER_FEAT, OF0_V);
    wr(LMQ_OFS_OFFER_SEL, 32'h0000_0002);
    rd_chk(LMQ_OFS_OFFER_FEAT, LMQ_ZERO_WORD);
    for (int i = 0; i < LMQ_FEAT_WORDS; i++)
    begin
      val = $random(seed);
      wr(LMQ_OFS_ACCEPT_SEL, 32'(i));
      wr(LMQ_OFS_ACCEPT_FEAT, val);
      check({32'h0, i == 0 ? accepted_w0 : accepted_w1}, {32'h0, val});
    end
    // page size set before any ring
    page = 32'h1 << (10 + {$random(seed)} % 4);
    wr(LMQ_OFS_PAGE_BYTES, page);
    for (int i = 0; i < LMQ_NUM_RINGS; i++)
    begin
      cnt = 32'h1 + {$random(seed)} % MAX_V;
      algn = 32'h1 << (2 + {$random(seed)} % 8);
      fr[i] = ({$random(seed)} & 32'h000f_ffff) | 32'h1;
      if (i == LMQ_NUM_RINGS - 1)
        fr[i] = 32'hffff_ffff;
      wr(LMQ_OFS_RING_SEL, 32'(i));
      rd_chk(LMQ_OFS_PAGE_FRAME, LMQ_ZERO_WORD);
      rd_chk(LMQ_OFS_RING_MAX, MAX_V);
      wr(LMQ_OFS_RING_COUNT, cnt);
      wr(LMQ_OFS_USED_ALIGN, algn);
      wr(LMQ_OFS_PAGE_FRAME, fr[i]);
      repeat (3) @(posedge clk);
      #1;
      check(ring_base, 64'(fr[i]) * 64'(page));
      check(used_base, used_exp(64'(fr[i]) * 64'(page), cnt, algn));
      check({63'h0, ring_active}, 64'h1);
      rd_chk(LMQ_OFS_PAGE_FRAME, fr[i]);
    end
    // each index keeps its own frame
    for (int i = 0; i < LMQ_NUM_RINGS; i++)
    begin
      wr(LMQ_OFS_RING_SEL, 32'(i));
      rd_chk(LMQ_OFS_PAGE_FRAME, fr[i]);
    end
    wr(LMQ_OFS_RING_SEL, 32'(LMQ_NUM_RINGS));
    rd_chk(LMQ_OFS_RING_MAX, LMQ_ZERO_WORD);
    // Frame write to an absent ring is ignored
    wr(LMQ_OFS_PAGE_FRAME, 32'h0000_0055);
    rd_chk(LMQ_OFS_PAGE_FRAME, LMQ_ZERO_WORD);
    wr(LMQ_OFS_RING_SEL, 32'h0000_0000);
    rd_chk(LMQ_OFS_PAGE_FRAME, fr[0]);
    wr(LMQ_OFS_RING_SEL, 32'h0000_0002);
    wr(LMQ_OFS_PAGE_FRAME, 32'h0000_0000);
    rd_chk(LMQ_OFS_PAGE_FRAME, LMQ_ZERO_WORD);
    repeat (3) @(posedge clk);
    #1;
    check({63'h0, ring_active}, 64'h0);
    val = $random(seed);
    wr(LMQ_OFS_DOORBELL, val);
    check({63'h0, doorbell_pulse}, 64'h1);
    check({48'h0, doorbell_ring}, {48'h0, val[15:0]});
    @(posedge clk);
    #1;
    check({63'h0, doorbell_pulse}, 64'h0);
    @(posedge clk);
    event_set <= 2'b11;
    @(posedge clk);
    event_set <= 2'b00;
    repeat (4) @(posedge clk);
    #1;
    check({63'h0, irq}, 64'h1);
    rd_chk(LMQ_OFS_EVENT_FLAGS, 32'h0000_0003);
    wr(LMQ_OFS_EVENT_CLEAR, 32'h0000_0001);
    check({63'h0, irq}, 64'h1);
    rd_chk(LMQ_OFS_EVENT_FLAGS, 32'h0000_0002);
    wr(LMQ_OFS_EVENT_CLEAR, 32'h0000_0002);
    check({63'h0, irq}, 64'h0);
    // status flags, then zero clears every frame
    wr(LMQ_OFS_STATUS, 32'h0000_0007);
    check({32'h0, dev_status}, 64'h7);
    wr(LMQ_OFS_STATUS, 32'h0000_0000);
    check({32'h0, dev_status}, 64'h0);
    for (int i = 0; i < LMQ_NUM_RINGS; i++)
    begin
      wr(LMQ_OFS_RING_SEL, 32'(i));
      rd_chk(LMQ_OFS_PAGE_FRAME, LMQ_ZERO_WORD);
    end
    // Clock enable low ignores a status write
    @(posedge clk);
    ce <= 1'b0;
    wr(LMQ_OFS_STATUS, 32'h0000_0005);
    check({32'h0, dev_status}, 64'h0);
    @(posedge clk);
    ce <= 1'b1;
    give_verdict();
  end
endmodule
